//--- include/umcl_pkg.sv
// package of constants and types for the modem handshake control block
package umcl_pkg;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } umcl_busreq_s;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_HANDSHAKE_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_LINE_STATUS    = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_FLOW_CTRL_LOW  = 4'h2;

    // ------------------------------------------------------------
    // modem_handshake_control fields
    // ------------------------------------------------------------
    localparam int HC_RCV_ENABLE    = 1;
    localparam int HC_LOOP          = 2;
    localparam int HC_RESERVED      = 3;
    localparam int HC_DTR           = 4;
    localparam int HC_RTS           = 5;
    localparam int HC_LOOP_RING     = 6;
    localparam int HC_LOOP_CARRIER  = 7;
    localparam logic [DATA_W-1:0] HC_WRITE_MASK = 8'hfe;
    localparam logic [DATA_W-1:0] HC_RESET      = 8'h00;

    // ------------------------------------------------------------
    // modem_line_status fields
    // ------------------------------------------------------------
    localparam int LS_CLEAR_TO_SEND = 4;
    localparam int LS_SET_READY     = 5;
    localparam int LS_RING          = 6;
    localparam int LS_CARRIER       = 7;

    // ------------------------------------------------------------
    // flow_control_low fields
    // ------------------------------------------------------------
    localparam int FC_RX_RTS_FLOW   = 5;
    localparam int FC_RX_DTR_FLOW   = 6;
    localparam int FC_MULTIDROP     = 7;
    localparam logic [DATA_W-1:0] FC_RESET = 8'h00;

    // ------------------------------------------------------------
    // pin inputs, order inside the synchroniser
    // ------------------------------------------------------------
    localparam int PIN_CNT      = 5;
    localparam int PIN_CTS      = 0;
    localparam int PIN_DSR      = 1;
    localparam int PIN_RI       = 2;
    localparam int PIN_DCD      = 3;
    localparam int PIN_SIN      = 4;
    localparam logic [PIN_CNT-1:0] PIN_IDLE = 5'h1f;

endpackage : umcl_pkg

//--- hw/umcl_pin_sync.sv
// two flip-flop synchroniser for the asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none

module umcl_pin_sync #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // pins and synchronised levels
    input  wire logic [WIDTH-1:0] pinIn,
    output var  logic [WIDTH-1:0] pinSync
);

    // ------------------------------------------------------------
    // one chain per pin; first stage feeds only the second
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_chain
            logic stage1;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    stage1     <= IDLE[i];
                    pinSync[i] <= IDLE[i];
                end else begin
                    stage1     <= pinIn[i];
                    pinSync[i] <= stage1;
                end
            end
        end
    endgenerate

endmodule : umcl_pin_sync

`default_nettype wire

//--- hw/umcl_modem_control.sv
// modem handshake control, loop-back and modem status for the serial port
//
// Summary of operation
// - in loop-back, data-terminal-ready control bit reads as modem status bit 4
// - in loop-back, request-to-send control bit reads as modem status bit 5
// - in loop-back, loop ring-indicator control bit reads as modem status bit 6
// - in loop-back, loop carrier-detect control bit reads as modem status bit 7
// - control bit 4 drives the low-active terminal ready pin, resets to 0
// - control bit 5 drives the low-active request-to-send pin, resets to 0
// - manual pin bits ignored under auto-flow control or multidrop bus mode
// - control bit 6 only matters in loop-back, copied into status bit 6
// - control bit 7 only matters in loop-back, copied into status bit 7
// - control bit 2 selects loop-back: serial out high, transmitter feeds receiver
// - in loop-back the four external modem inputs are disconnected
// - flow control bit 7 selects multidrop bus mode, overriding manual pin bits
`timescale 1ns/10ps
`default_nettype none

module umcl_modem_control (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       softReset,
    // register port
    input  wire umcl_pkg::umcl_busreq_s     busReq,
    output var  logic [umcl_pkg::DATA_W-1:0] rdData,
    // modem pins, low active
    input  wire logic                       ctsPinN,
    input  wire logic                       dsrPinN,
    input  wire logic                       riPinN,
    input  wire logic                       dcdPinN,
    output var  logic                       dtrPinN,
    output var  logic                       rtsPinN,
    // serial pins
    input  wire logic                       serialInPin,
    output var  logic                       serialOutPin,
    // transmitter and receiver side
    input  wire logic                       txSerial,
    input  wire logic                       txBusy,
    output var  logic                       rxSerial,
    output var  logic                       rxEnable,
    // automatic flow control requests
    input  wire logic                       autoDtrAssert,
    input  wire logic                       autoRtsAssert
);
    import umcl_pkg::*;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic [PIN_CNT-1:0] pinRaw;
    logic [PIN_CNT-1:0] pinSync;

    always_comb begin
        pinRaw          = PIN_IDLE;
        pinRaw[PIN_CTS] = ctsPinN;
        pinRaw[PIN_DSR] = dsrPinN;
        pinRaw[PIN_RI]  = riPinN;
        pinRaw[PIN_DCD] = dcdPinN;
        pinRaw[PIN_SIN] = serialInPin;
    end

    umcl_pin_sync #(
        .WIDTH (PIN_CNT),
        .IDLE  (PIN_IDLE)
    ) u_pin_sync (
        .clk     (clk),
        .rst     (rst),
        .pinIn   (pinRaw),
        .pinSync (pinSync)
    );

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] handshakeCtrl;
    logic [DATA_W-1:0] flowCtrlLow;
    logic [DATA_W-1:0] next_handshakeCtrl;
    logic [DATA_W-1:0] next_flowCtrlLow;

    // soft reset clears control bits just like the hard reset
    always_comb begin
        next_handshakeCtrl = handshakeCtrl;
        next_flowCtrlLow   = flowCtrlLow;
        if (softReset) begin
            next_handshakeCtrl = HC_RESET;
            next_flowCtrlLow   = FC_RESET;
        end else if (busReq.wr) begin
            if (busReq.addr == OFS_HANDSHAKE_CTRL) begin
                // bit 3 is kept for readback only
                next_handshakeCtrl = busReq.wdata & HC_WRITE_MASK;
            end else if (busReq.addr == OFS_FLOW_CTRL_LOW) begin
                next_flowCtrlLow = busReq.wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            handshakeCtrl <= HC_RESET;
            flowCtrlLow   <= FC_RESET;
        end else begin
            handshakeCtrl <= next_handshakeCtrl;
            flowCtrlLow   <= next_flowCtrlLow;
        end
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic loopMode;
    logic multidrop;
    logic autoDtrFlow;
    logic autoRtsFlow;

    always_comb begin
        loopMode    = handshakeCtrl[HC_LOOP];
        multidrop   = flowCtrlLow[FC_MULTIDROP];
        autoDtrFlow = flowCtrlLow[FC_RX_DTR_FLOW];
        autoRtsFlow = flowCtrlLow[FC_RX_RTS_FLOW];
    end

    // ------------------------------------------------------------
    // modem status, bits 4 to 7
    // ------------------------------------------------------------
    logic [DATA_W-1:0] lineStatus;
    logic [DATA_W-1:0] next_lineStatus;

    // external pins are low active, status bits are high active
    always_comb begin
        next_lineStatus = '0;
        if (loopMode) begin
            // external inputs play no part here
            next_lineStatus[LS_CLEAR_TO_SEND] = handshakeCtrl[HC_DTR];
            next_lineStatus[LS_SET_READY]     = handshakeCtrl[HC_RTS];
            next_lineStatus[LS_RING]          = handshakeCtrl[HC_LOOP_RING];
            next_lineStatus[LS_CARRIER]       = handshakeCtrl[HC_LOOP_CARRIER];
        end else begin
            next_lineStatus[LS_CLEAR_TO_SEND] = ~pinSync[PIN_CTS];
            next_lineStatus[LS_SET_READY]     = ~pinSync[PIN_DSR];
            next_lineStatus[LS_RING]          = ~pinSync[PIN_RI];
            next_lineStatus[LS_CARRIER]       = ~pinSync[PIN_DCD];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lineStatus <= '0;
        end else begin
            lineStatus <= next_lineStatus;
        end
    end

    // ------------------------------------------------------------
    // handshake output pins
    // ------------------------------------------------------------
    logic next_dtrPinN;
    logic next_rtsPinN;

    // in multidrop mode the line driver follows the transmitter,
    // so terminal ready is left inactive there
    always_comb begin
        if (multidrop) begin
            next_dtrPinN = 1'b1;
            next_rtsPinN = ~txBusy;
        end else begin
            if (autoDtrFlow) begin
                next_dtrPinN = ~autoDtrAssert;
            end else begin
                next_dtrPinN = ~handshakeCtrl[HC_DTR];
            end
            if (autoRtsFlow) begin
                next_rtsPinN = ~autoRtsAssert;
            end else begin
                next_rtsPinN = ~handshakeCtrl[HC_RTS];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dtrPinN <= 1'b1;
            rtsPinN <= 1'b1;
        end else begin
            dtrPinN <= next_dtrPinN;
            rtsPinN <= next_rtsPinN;
        end
    end

    // ------------------------------------------------------------
    // serial path and receiver enable
    // ------------------------------------------------------------
    logic next_serialOutPin;
    logic next_rxSerial;
    logic next_rxEnable;

    // one flop of delay on the loop path; the receiver samples
    // many clocks per bit, so this costs nothing
    always_comb begin
        if (loopMode) begin
            next_serialOutPin = 1'b1;
            next_rxSerial     = txSerial;
        end else begin
            next_serialOutPin = txSerial;
            next_rxSerial     = pinSync[PIN_SIN];
        end
        next_rxEnable = 1'b1;
        if (multidrop && !handshakeCtrl[HC_RCV_ENABLE] && txBusy) begin
            next_rxEnable = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serialOutPin <= 1'b1;
            rxSerial     <= 1'b1;
            rxEnable     <= 1'b1;
        end else begin
            serialOutPin <= next_serialOutPin;
            rxSerial     <= next_rxSerial;
            rxEnable     <= next_rxEnable;
        end
    end

    // ------------------------------------------------------------
    // register readback
    // ------------------------------------------------------------
    logic [DATA_W-1:0] next_rdData;

    // unmapped offsets read as zero
    always_comb begin
        next_rdData = '0;
        if (busReq.rd) begin
            if (busReq.addr == OFS_HANDSHAKE_CTRL) begin
                next_rdData = handshakeCtrl;
            end else if (busReq.addr == OFS_LINE_STATUS) begin
                next_rdData = lineStatus;
            end else if (busReq.addr == OFS_FLOW_CTRL_LOW) begin
                next_rdData = flowCtrlLow;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData <= '0;
        end else begin
            rdData <= next_rdData;
        end
    end

endmodule : umcl_modem_control

`default_nettype wire

//--- tb/umcl_modem_control_assertions.sv
// port checks for the modem handshake control block
`timescale 1ns/10ps
`default_nettype none

module umcl_modem_control_assertions (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  softReset,
    // register port
    input wire umcl_pkg::umcl_busreq_s busReq,
    input wire logic [7:0]            rdData,
    // pins and serial path
    input wire logic                  dtrPinN,
    input wire logic                  rtsPinN,
    input wire logic                  serialOutPin,
    input wire logic                  txSerial,
    input wire logic                  txBusy,
    input wire logic                  rxSerial,
    input wire logic                  autoDtrAssert,
    input wire logic                  autoRtsAssert
);
    import umcl_pkg::*;
    // ----
    // shadow of the writable registers
    // ----
    logic [7:0] hc;
    logic [7:0] fc;
    logic [7:0] next_hc;
    logic [7:0] next_fc;
    always_comb begin
        next_hc = hc;
        next_fc = fc;
        if (busReq.wr && busReq.addr == OFS_HANDSHAKE_CTRL) next_hc = busReq.wdata & HC_WRITE_MASK;
        if (busReq.wr && busReq.addr == OFS_FLOW_CTRL_LOW) next_fc = busReq.wdata;
        // soft reset wins over a same-cycle write
        if (softReset) next_hc = HC_RESET;
        if (softReset) next_fc = FC_RESET;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hc <= HC_RESET;
            fc <= FC_RESET;
        end else begin
            hc <= next_hc;
            fc <= next_fc;
        end
    end
    // ----
    // assertions
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_status_read;
        busReq.rd && busReq.addr == OFS_LINE_STATUS && $past(hc[HC_LOOP]);
    endsequence
    sequence s_ctrl_read;
        busReq.rd && busReq.addr == OFS_HANDSHAKE_CTRL;
    endsequence
    a_loop_status: assert property (s_status_read |=> rdData == {$past(hc[7:4], 2), 4'h0})
        else $error("looped status bits wrong");
    a_ctrl_readback: assert property (s_ctrl_read |=> rdData == $past(hc))
        else $error("control readback wrong");
    a_read_idle: assert property (!busReq.rd |=> rdData == 8'h00)
        else $error("read data not cleared");
    a_dtr_manual: assert property ($past(fc[7:6] == 2'h0) |-> dtrPinN == !$past(hc[HC_DTR]))
        else $error("terminal ready pin wrong");
    a_rts_manual: assert property ($past(fc[7] == 1'b0 && fc[5] == 1'b0) |-> rtsPinN == !$past(hc[HC_RTS]))
        else $error("request pin wrong");
    a_dtr_auto: assert property ($past(fc[7:6] == 2'h1) |-> dtrPinN == !$past(autoDtrAssert))
        else $error("auto terminal ready wrong");
    a_rts_auto: assert property ($past(fc[7] == 1'b0 && fc[5] == 1'b1) |-> rtsPinN == !$past(autoRtsAssert))
        else $error("auto request pin wrong");
    a_multidrop_pins: assert property ($past(fc[7]) |-> dtrPinN && rtsPinN == !$past(txBusy))
        else $error("multidrop pins wrong");
    a_loop_serial: assert property ($past(hc[HC_LOOP]) |-> serialOutPin && rxSerial == $past(txSerial))
        else $error("loop serial path wrong");
endmodule : umcl_modem_control_assertions
`default_nettype wire

//--- tb/umcl_modem_partner.sv
// modem on the far side of the handshake pins
`timescale 1ns/10ps
`default_nettype none

module umcl_modem_partner (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // asserted levels: carrier, ring, set ready, clear to send
    input  wire logic [3:0] modemLevel,
    // modem pins, low active
    output var  logic       ctsPinN,
    output var  logic       dsrPinN,
    output var  logic       riPinN,
    output var  logic       dcdPinN,
    output var  logic       serialInPin
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {dcdPinN, riPinN, dsrPinN, ctsPinN} <= 4'hf;
            serialInPin <= 1'b1;
        end else begin
            {dcdPinN, riPinN, dsrPinN, ctsPinN} <= ~modemLevel;
            // line noise, so a leaking serial input shows in loop-back
            serialInPin <= ~serialInPin;
        end
    end
endmodule : umcl_modem_partner
`default_nettype wire

//--- tb/umcl_modem_control_test.sv
// self-checking bench for the modem handshake control block
`timescale 1ns/10ps
`default_nettype none

module umcl_modem_control_test;
    import umcl_pkg::*;
    logic clk, rst, softReset, txSerial, txBusy, autoDtrAssert, autoRtsAssert;
    logic ctsPinN, dsrPinN, riPinN, dcdPinN, dtrPinN, rtsPinN, serialInPin;
    logic serialOutPin, rxSerial, rxEnable;
    logic [3:0] modemLevel;
    logic [7:0] rdData;
    umcl_busreq_s busReq;
    int err_count, total_checks;

    umcl_modem_control u_dut (.clk, .rst, .softReset, .busReq, .rdData,
        .ctsPinN, .dsrPinN, .riPinN, .dcdPinN, .dtrPinN, .rtsPinN, .serialInPin,
        .serialOutPin, .txSerial, .txBusy, .rxSerial, .rxEnable,
        .autoDtrAssert, .autoRtsAssert);
    umcl_modem_partner u_modem (.clk, .rst, .modemLevel,
        .ctsPinN, .dsrPinN, .riPinN, .dcdPinN, .serialInPin);

    // ----
    // tasks
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq.addr <= a;
        busReq.wdata <= d;
        busReq.wr <= 1'b1;
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        busReq.addr <= a;
        busReq.rd <= 1'b1;
        @(posedge clk);
        busReq.rd <= 1'b0;
        @(negedge clk);
        check(rdData, e);
    endtask : rd_chk
    // compares {rtsPinN, dtrPinN} after n edges
    task automatic pins(input int n, input logic [1:0] e);
        repeat (n) @(posedge clk);
        @(negedge clk);
        check({6'h0, rtsPinN, dtrPinN}, {6'h0, e});
    endtask : pins
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // ----
    // clock, watchdog, tests
    // ----
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        final_report();
    end
    initial begin
        {rst, softReset, txSerial, txBusy, autoDtrAssert, autoRtsAssert} = 6'h20;
        busReq = '0;
        modemLevel = 4'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(OFS_HANDSHAKE_CTRL, 8'h00);
        pins(0, 2'b11);
        wr_reg(OFS_HANDSHAKE_CTRL, 8'h39);
        rd_chk(OFS_HANDSHAKE_CTRL, 8'h38);
        pins(0, 2'b00);
        wr_reg(OFS_HANDSHAKE_CTRL, 8'hd0);
        pins(1, 2'b10);
        for (int i = 0; i < 16; i += 5) begin
            modemLevel <= 4'(i);
            repeat (6) @(posedge clk);
            rd_chk(OFS_LINE_STATUS, {4'(i), 4'h0});
        end
        // outside pins all held asserted while one looped bit is set at a time
        for (int b = 4; b < 8; b++) begin
            wr_reg(OFS_HANDSHAKE_CTRL, 8'h04 | (8'h01 << b));
            @(posedge clk);
            rd_chk(OFS_LINE_STATUS, 8'h01 << b);
        end
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            txSerial <= 1'(v);
            @(posedge clk);
            @(negedge clk);
            check({6'h0, serialOutPin, rxSerial}, {7'h01, 1'(v)});
        end
        wr_reg(OFS_HANDSHAKE_CTRL, 8'h30);
        wr_reg(OFS_FLOW_CTRL_LOW, 8'h80);
        txBusy <= 1'b1;
        pins(2, 2'b01);
        check({7'h0, rxEnable}, 8'h00);
        @(posedge clk);
        txBusy <= 1'b0;
        pins(2, 2'b11);
        check({7'h0, rxEnable}, 8'h01);
        wr_reg(OFS_FLOW_CTRL_LOW, 8'h60);
        autoDtrAssert <= 1'b1;
        pins(2, 2'b10);
        wr_reg(OFS_HANDSHAKE_CTRL, 8'h00);
        autoDtrAssert <= 1'b0;
        autoRtsAssert <= 1'b1;
        pins(2, 2'b01);
        wr_reg(OFS_LINE_STATUS, 8'hff);
        rd_chk(4'hf, 8'h00);
        wr_reg(OFS_HANDSHAKE_CTRL, 8'h30);
        softReset <= 1'b1;
        @(posedge clk);
        softReset <= 1'b0;
        rd_chk(OFS_HANDSHAKE_CTRL, 8'h00);
        rd_chk(OFS_FLOW_CTRL_LOW, 8'h00);
        rd_chk(OFS_LINE_STATUS, 8'hf0);
        pins(0, 2'b11);
        final_report();
    end
endmodule : umcl_modem_control_test

bind umcl_modem_control umcl_modem_control_assertions u_chk (.clk, .rst, .softReset, .busReq,
    .rdData, .dtrPinN, .rtsPinN, .serialOutPin, .txSerial, .txBusy, .rxSerial, .autoDtrAssert,
    .autoRtsAssert);
`default_nettype wire
